// ==== src/reset_exception_consts.svh ====
// timing counts, field positions and reset values for the reset/exception block
// assumes inclusion by bare name; definitions only
`ifndef RESET_EXCEPTION_CONSTS_SVH
`define RESET_EXCEPTION_CONSTS_SVH
`define PRESCALE_WIDTH 13
`define PRESCALE_CLEAR_LO 4
`define POR_HOLD_CYCLES 13'h1000
`define RELEASE_CYCLES 13'h0040
`define PIN_DRIVE_CYCLES 13'h0020
`define STOP_SHORT_CYCLES 13'h0020
`define STOP_LONG_CYCLES 13'h1000
`define WATCHDOG_WIDTH 8
`define WATCHDOG_TOP 8'hff
`define CAUSE_POR 0
`define CAUSE_PIN 1
`define CAUSE_WATCHDOG 2
`define CAUSE_ILLEGAL_OP 3
`define CAUSE_ILLEGAL_ADDR 4
`define CAUSE_LOW_SUPPLY 5
`define CAUSE_RESET_VALUE 6'h01
`define IRQ_COUNT 8
`define IRQ_CODE_WIDTH 3
`define APB_OFS_CAUSE 12'h000
`define APB_OFS_SERVICE 12'h004
`define APB_OFS_OPTIONS 12'h008
`define APB_OFS_IRQ_ENABLE 12'h00c
`define APB_OFS_STATUS 12'h010
`define APB_ADDR_WIDTH 12
`endif

// ==== src/reset_exception_pkg.sv ====
// types shared by the reset/exception sequencer and its helpers
// assumes the constants header is on the include path
`include "reset_exception_consts.svh"
package reset_exception_pkg;
	typedef enum logic [4:0] {
		seq_run = 5'b00001,
		seq_hold = 5'b00010,
		seq_pin = 5'b00100,
		seq_tail = 5'b01000,
		seq_stop = 5'b10000
	} seq_state_t;
	typedef struct packed {
		logic illegal_op;
		logic stop_decoded;
		logic opcode_fetch;
		logic unmapped;
		logic insn_done;
		logic mask_set;
		logic return_int;
	} cpu_status_t;
	typedef struct packed {
		logic valid;
		logic [`IRQ_CODE_WIDTH-1:0] code;
	} irq_grant_t;
endpackage : reset_exception_pkg

// ==== src/prescale_counter.sv ====
// 13-bit prescale counter advanced on falling crystal reference edges
// assumes the reference edge arrives as a synchronous one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module prescale_counter
	import reset_exception_pkg::*;
#(
	parameter int WIDTH = `PRESCALE_WIDTH
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// control
	input wire logic ref_fall,
	input wire logic clear_all,
	input wire logic clear_high,
	// result
	output logic [WIDTH-1:0] count,
	output logic overflow
);
	logic [WIDTH-1:0] count_reg;
	logic overflow_reg;
	// counts reference falls; a service clears only the upper bits
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			count_reg <= '0;
		end else if (clear_all) begin
			count_reg <= '0;
		end else if (clear_high) begin
			count_reg <= {{(WIDTH-`PRESCALE_CLEAR_LO){1'b0}},
				count_reg[`PRESCALE_CLEAR_LO-1:0]}; // RL6
		end else if (ref_fall) begin
			count_reg <= count_reg + 1'b1; // RL7
		end
	end
	// overflow pulse drives the watchdog
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			overflow_reg <= 1'b0;
		end else begin
			overflow_reg <= ref_fall && !clear_all && !clear_high &&
				(&count_reg); // RL7
		end
	end
	assign count = count_reg;
	assign overflow = overflow_reg;
endmodule : prescale_counter
`default_nettype wire

// ==== src/irq_arbiter.sv ====
// interrupt latch and fixed-priority arbiter, lowest index wins
// assumes request lines are synchronous to clock
`timescale 1ns/1ps
`default_nettype none
module irq_arbiter
	import reset_exception_pkg::*;
#(
	parameter int COUNT = `IRQ_COUNT
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// requests and qualifiers
	input wire logic [COUNT-1:0] pending,
	input wire logic [COUNT-1:0] enable,
	input wire logic boundary,
	input wire logic mask_set,
	input wire logic serviced,
	// outcome
	output irq_grant_t grant
);
	irq_grant_t grant_reg;
	logic [COUNT-1:0] live;
	logic [`IRQ_CODE_WIDTH-1:0] pick;
	logic any;
	// priority pick among enabled pending sources
	always_comb begin
		live = pending & enable; // RL18
		pick = '0;
		any = 1'b0;
		for (int i = COUNT-1; i >= 0; i--) begin
			if (live[i]) begin
				pick = i[`IRQ_CODE_WIDTH-1:0]; // RL19
				any = 1'b1;
			end
		end
	end
	// once latched the grant holds until serviced or the mask clears;
	// a return boundary may latch the next pending source at once
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			grant_reg <= '0;
		end else if (boundary && !mask_set && any &&
			(!grant_reg.valid || serviced)) begin
			grant_reg.valid <= 1'b1; // RL16 RL21
			grant_reg.code <= pick; // RL17
		end else if (grant_reg.valid && (serviced || !mask_set)) begin
			grant_reg.valid <= 1'b0; // RL16
		end
	end
	assign grant = grant_reg;
endmodule : irq_arbiter
`default_nettype wire

// ==== src/reset_exception_sequencer.sv ====
// reset source recorder, reset pin driver, stop recovery and irq front end
// assumes an APB master on clock, crystal reference and pins asynchronous
//
// Behaviour
// RL1: power-on holds pin low 4096 reference cycles, releases 64 later
// RL2: power-on sets power-on cause, clears all other causes
// RL3: power-on asserts internal reset, enables clock out, gates core clocks
// RL4: watchdog overflow resets and sets watchdog cause
// RL5: every internal reset source drives the reset pin low; a low supply seen in tail or stop state leaves the pin undriven
// RL6: write to service word clears watchdog and prescale bits 12..4
// RL7: 13-bit prescaler on falling reference edge clocks the watchdog
// RL8: watchdog disabled only by high-voltage detect in monitor or break
// RL9: illegal instruction sets illegal opcode cause and resets
// RL10: stop with stop-enable option 0 is an illegal opcode reset
// RL11: opcode fetch from unmapped address sets fetch cause, resets
// RL12: low supply sets cause, holds pin 4096 cycles, releases 64 later; the hold is applied only to low supply seen in run state
// RL13: stop instruction clears the prescaler, which times recovery
// RL14: stop exit recovery lasts 32 cycles if short option, else 4096
// RL15: pin reset leaves prescaler alone; prescaler free runs after reset
// RL16: interrupts latched; latched one holds until serviced or mask clears
// RL17: arbitration result is a vector code for the CPU
// RL18: interrupts evaluated at instruction end, unmasked and enabled only
// RL19: highest priority pending interrupt serviced first
// RL20: entry stacks registers and sets mask; return restores them
// RL21: interrupt pending at return is serviced before next instruction
// RL22: entry does not stack the high index register
// RL23: internal source drives pin 32 cycles, internal reset 32 more
// RL24: reading the reset cause register clears its flags
`timescale 1ns/1ps
`default_nettype none
module reset_exception_sequencer
	import reset_exception_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// reference clock and pins
	input wire logic crystal_ref_clock,
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	input wire logic high_voltage_detect,
	input wire logic monitor_mode,
	input wire logic break_state,
	input wire logic low_supply_monitor,
	// cpu side
	input wire cpu_status_t cpu,
	input wire logic [`IRQ_COUNT-1:0] irq_pending,
	output irq_grant_t irq_grant,
	output logic internal_reset,
	output logic core_clock_enable,
	output logic generated_clock_out_enable,
	output logic stop_active,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`APB_ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	// synchronisers: first stage read only by the second
	logic [2:0] ref_sync_reg;
	logic [1:0] pin_sync_reg;
	logic [1:0] hv_sync_reg;
	logic [1:0] lvi_sync_reg;
	logic ref_fall;
	logic pin_low;
	logic hv_seen;
	logic lvi_seen;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ref_sync_reg <= 3'h0;
			pin_sync_reg <= 2'h3;
			hv_sync_reg <= 2'h0;
			lvi_sync_reg <= 2'h0;
		end else begin
			ref_sync_reg <= {ref_sync_reg[1:0], crystal_ref_clock};
			pin_sync_reg <= {pin_sync_reg[0], reset_pin_in};
			hv_sync_reg <= {hv_sync_reg[0], high_voltage_detect};
			lvi_sync_reg <= {lvi_sync_reg[0], low_supply_monitor};
		end
	end
	assign ref_fall = ref_sync_reg[2] && !ref_sync_reg[1]; // RL7
	assign pin_low = !pin_sync_reg[1];
	assign hv_seen = hv_sync_reg[1];
	assign lvi_seen = lvi_sync_reg[1];

	// apb decode: zero wait states, unmapped offsets answer slverr
	logic apb_access;
	logic wr_service;
	logic wr_options;
	logic wr_enable;
	logic rd_cause;
	logic mapped;
	assign apb_access = psel && penable;
	assign mapped = (paddr == `APB_OFS_CAUSE) || (paddr == `APB_OFS_SERVICE)
		|| (paddr == `APB_OFS_OPTIONS) || (paddr == `APB_OFS_IRQ_ENABLE)
		|| (paddr == `APB_OFS_STATUS);
	assign wr_service = apb_access && pwrite && paddr == `APB_OFS_SERVICE;
	assign wr_options = apb_access && pwrite && paddr == `APB_OFS_OPTIONS;
	assign wr_enable = apb_access && pwrite && paddr == `APB_OFS_IRQ_ENABLE;
	assign rd_cause = apb_access && !pwrite && paddr == `APB_OFS_CAUSE;
	assign pready = 1'b1;
	assign pslverr = apb_access && !mapped;

	// option bits: bit0 stop enable, bit1 short stop recovery
	logic stop_enable_reg;
	logic short_stop_recovery_reg;
	logic [`IRQ_COUNT-1:0] irq_enable_reg;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			stop_enable_reg <= 1'b0;
			short_stop_recovery_reg <= 1'b0;
		end else if (wr_options) begin
			stop_enable_reg <= pwdata[0];
			short_stop_recovery_reg <= pwdata[1];
		end
	end
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			irq_enable_reg <= '0;
		end else if (wr_enable) begin
			irq_enable_reg <= pwdata[`IRQ_COUNT-1:0];
		end
	end

	// sequencer state
	seq_state_t state_reg;
	logic [`PRESCALE_WIDTH-1:0] prescale;
	logic prescale_ovf;
	logic prescale_clear;
	logic [`WATCHDOG_WIDTH-1:0] watchdog_reg;
	logic watchdog_fire;
	logic watchdog_disable;
	logic stop_exec;
	logic illegal_opcode_flag_src;
	logic illegal_fetch_address_flag_src;
	logic internal_src;
	logic long_hold_reg;
	logic por_pending_reg;
	logic stop_exit;
	logic [`PRESCALE_WIDTH-1:0] stop_target_reg;

	// noise on pins cannot turn the watchdog off: high voltage required
	assign watchdog_disable = hv_seen && (monitor_mode || break_state); // RL8
	assign watchdog_fire = !watchdog_disable && prescale_ovf &&
		watchdog_reg == `WATCHDOG_TOP; // RL4
	assign stop_exec = cpu.stop_decoded && stop_enable_reg &&
		state_reg == seq_run;
	assign illegal_opcode_flag_src = state_reg == seq_run && (cpu.illegal_op ||
		(cpu.stop_decoded && !stop_enable_reg)); // RL9 RL10
	assign illegal_fetch_address_flag_src = state_reg == seq_run && cpu.opcode_fetch &&
		cpu.unmapped; // RL11
	assign internal_src = illegal_opcode_flag_src || illegal_fetch_address_flag_src || watchdog_fire ||
		(lvi_seen && state_reg != seq_hold);
	assign stop_exit = state_reg == seq_stop && (|irq_pending || pin_low);
	// counter is cleared on every internal reset entry but not by the pin
	assign prescale_clear = stop_exec || internal_src; // RL13 RL15

	prescale_counter #(
		.WIDTH(`PRESCALE_WIDTH)
	) u_prescale (
		.clock(clock),
		.nrst(nrst),
		.ref_fall(ref_fall && !(state_reg == seq_stop && !stop_exit &&
			stop_target_reg == '0)),
		.clear_all(prescale_clear),
		.clear_high(wr_service),
		.count(prescale),
		.overflow(prescale_ovf)
	);

	// watchdog counter, clocked by prescale overflow
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			watchdog_reg <= '0;
		end else if (wr_service || watchdog_disable) begin
			watchdog_reg <= '0; // RL6
		end else if (prescale_ovf) begin
			watchdog_reg <= watchdog_reg + 1'b1; // RL7
		end
	end

	// power-on pending: nrst release counts as power-on
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			por_pending_reg <= 1'b1;
		end else if (state_reg == seq_hold) begin
			por_pending_reg <= 1'b0;
		end
	end

	// reset and stop sequencing
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_reg <= seq_hold; // RL1 RL3
			long_hold_reg <= 1'b1;
			stop_target_reg <= '0;
		end else begin
			unique case (state_reg)
				seq_run: begin
					if (internal_src) begin
						state_reg <= lvi_seen ? seq_hold : seq_pin; // RL5 RL12
						long_hold_reg <= lvi_seen;
					end else if (stop_exec) begin
						state_reg <= seq_stop;
						stop_target_reg <= '0;
					end
				end
				seq_hold: begin
					if (ref_fall && prescale == `POR_HOLD_CYCLES - 1'b1 &&
						!lvi_seen) begin
						state_reg <= seq_tail; // RL1 RL12
					end
				end
				seq_pin: begin
					if (ref_fall && prescale == `PIN_DRIVE_CYCLES - 1'b1) begin
						state_reg <= seq_tail; // RL23
					end
				end
				seq_tail: begin
					if (ref_fall && prescale == (long_hold_reg ?
						`POR_HOLD_CYCLES + `RELEASE_CYCLES :
						`PIN_DRIVE_CYCLES + `PIN_DRIVE_CYCLES) - 1'b1) begin
						state_reg <= seq_run; // RL1 RL23
					end
				end
				seq_stop: begin
					if (stop_exit && stop_target_reg == '0) begin
						stop_target_reg <= short_stop_recovery_reg ?
							`STOP_SHORT_CYCLES : `STOP_LONG_CYCLES; // RL14
					end else if (stop_target_reg != '0 && ref_fall &&
						prescale == stop_target_reg - 1'b1) begin
						state_reg <= seq_run; // RL14
						stop_target_reg <= '0;
					end
				end
			endcase
		end
	end

	// pin is driven in hold and pin states; internal reset covers hold, pin and tail
	assign reset_pin_oe = state_reg == seq_hold || state_reg == seq_pin; // RL5
	assign reset_pin_out = 1'b0;
	assign internal_reset = state_reg != seq_run && state_reg != seq_stop;
	assign core_clock_enable = state_reg == seq_run; // RL3
	assign generated_clock_out_enable = state_reg != seq_stop; // RL3
	assign stop_active = state_reg == seq_stop;

	// reset cause flags; a set in the read cycle wins over the clear
	logic [5:0] cause_reg;
	logic [5:0] cause_set;
	always_comb begin
		cause_set = 6'h00;
		cause_set[`CAUSE_WATCHDOG] = watchdog_fire; // RL4
		cause_set[`CAUSE_ILLEGAL_OP] = illegal_opcode_flag_src; // RL9 RL10
		cause_set[`CAUSE_ILLEGAL_ADDR] = illegal_fetch_address_flag_src; // RL11
		cause_set[`CAUSE_LOW_SUPPLY] = lvi_seen && state_reg != seq_hold; // RL12
		cause_set[`CAUSE_PIN] = pin_low && state_reg == seq_run;
	end
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cause_reg <= `CAUSE_RESET_VALUE; // RL2
		end else if (|cause_set) begin
			cause_reg <= cause_set; // RL12
		end else if (rd_cause) begin
			cause_reg <= 6'h00; // RL24
		end
	end

	// read data registered in the setup cycle, shown in access
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				`APB_OFS_CAUSE: prdata <= {26'h0, cause_reg};
				`APB_OFS_OPTIONS: prdata <= {30'h0, short_stop_recovery_reg,
					stop_enable_reg};
				`APB_OFS_IRQ_ENABLE: prdata <= {{(32-`IRQ_COUNT){1'b0}},
					irq_enable_reg};
				`APB_OFS_STATUS: prdata <= {19'h0, state_reg, watchdog_reg};
				default: prdata <= 32'h0;
			endcase
		end
	end

	// interrupt front end; the CPU stacks, sets the mask and restores
	// on return, without stacking the high index register
	irq_arbiter #(
		.COUNT(`IRQ_COUNT)
	) u_arbiter (
		.clock(clock),
		.nrst(nrst),
		.pending(irq_pending),
		.enable(irq_enable_reg),
		.boundary((cpu.insn_done || cpu.return_int) && state_reg == seq_run),
		.mask_set(cpu.mask_set), // RL20 RL22
		.serviced(cpu.return_int), // RL21
		.grant(irq_grant)
	);

	chk_pin_drive: assert property (@(posedge clock) disable iff (!nrst)
		internal_src |=> reset_pin_oe && internal_reset)
		else $error("internal source did not drive pin"); // RL5
	chk_cause_clear: assert property (@(posedge clock) disable iff (!nrst)
		rd_cause && !(|cause_set) |=> cause_reg == 6'h00)
		else $error("cause read did not clear"); // RL24
	chk_service_wd: assert property (@(posedge clock) disable iff (!nrst)
		wr_service |=> watchdog_reg == '0 && prescale[12:4] == 9'h000)
		else $error("service write did not clear counters"); // RL6
	chk_illegal_opcode_flag_cause: assert property (@(posedge clock) disable iff (!nrst)
		illegal_opcode_flag_src |=> cause_reg[`CAUSE_ILLEGAL_OP] && state_reg == seq_pin)
		else $error("illegal opcode not recorded"); // RL9
	chk_stop_clear: assert property (@(posedge clock) disable iff (!nrst)
		stop_exec |=> prescale == '0 && stop_active)
		else $error("stop did not clear prescaler"); // RL13
	chk_core_gate: assert property (@(posedge clock) disable iff (!nrst)
		internal_reset |-> !core_clock_enable)
		else $error("core clock ran in reset"); // RL3
	chk_wd_disable: assert property (@(posedge clock) disable iff (!nrst)
		watchdog_disable |=> watchdog_reg == '0)
		else $error("watchdog ran while disabled"); // RL8
	chk_grant_hold: assert property (@(posedge clock) disable iff (!nrst)
		irq_grant.valid && cpu.mask_set && !cpu.return_int |=>
		irq_grant.valid && $stable(irq_grant.code))
		else $error("latched grant was preempted"); // RL16
endmodule : reset_exception_sequencer
`default_nettype wire

// ==== dv/ref_pin_model.sv ====
// reference oscillator and wired reset pin standing beside the sequencer
// assumes the bench samples everything on the system clock
`timescale 1ns/1ps
`default_nettype none
module ref_pin_model #(
	parameter int HALF_NS = 20
) (
	// pin drivers
	input wire logic dut_pin_oe,
	input wire logic ext_pin_low,
	// outputs
	output logic crystal_ref_clock,
	output logic pin_level
);
	// free running: an oscillator never pauses between resets
	initial begin
		crystal_ref_clock = 1'b1;
		forever #(HALF_NS) crystal_ref_clock = ~crystal_ref_clock;
	end
	// open drain with pull-up, so any driver wins low
	assign pin_level = ~(dut_pin_oe | ext_pin_low);
endmodule : ref_pin_model
`default_nettype wire

// ==== dv/tb_top.sv ====
// bench for the reset/exception sequencer: apb, cpu pulses, timing counts
// assumes package and header compiled first; reference ticks are 4 clocks
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import reset_exception_pkg::*;
;
	logic clock, nrst, ext_low, low_supply, pin_level, ref_clk, rerr;
	logic psel, penable, pwrite, pready, pslverr, pin_oe, pin_out;
	logic int_rst, core_en, gen_en, stop_act, mask_lvl;
	logic [`APB_ADDR_WIDTH-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [`IRQ_COUNT-1:0] irq_pending;
	cpu_status_t cpu;
	irq_grant_t grant;
	int err_total, cmp_count, ticks, t0;
	logic [6:0] src [3] = '{7'h40, 7'h18, 7'h20};
	logic [31:0] cause_exp [3] = '{32'h08, 32'h10, 32'h08};

	ref_pin_model i_ref (.dut_pin_oe(pin_oe), .ext_pin_low(ext_low),
		.crystal_ref_clock(ref_clk), .pin_level(pin_level));
	reset_exception_sequencer i_dut (.clock(clock), .nrst(nrst),
		.crystal_ref_clock(ref_clk), .reset_pin_in(pin_level),
		.reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
		.high_voltage_detect(1'b0), .monitor_mode(1'b0), .break_state(1'b0),
		.low_supply_monitor(low_supply), .cpu(cpu), .irq_pending(irq_pending),
		.irq_grant(grant), .internal_reset(int_rst), .core_clock_enable(core_en),
		.generated_clock_out_enable(gen_en), .stop_active(stop_act),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// system clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// bench-side count of reference falls; sync delay allows two ticks slack
	always @(negedge ref_clk) ticks++;

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check_val

	task automatic check_near(input int got, input int exp);
		cmp_count++;
		if (got < exp - 2 || got > exp + 2) begin
			err_total++;
			$display("unexpected at %0t: %0d ticks want %0d", $time, got, exp);
		end
	endtask : check_near

	// one apb transfer; result lands in rd and rerr
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
			$display("unexpected at %0t: apb never ready", $time);
		end
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// one-cycle cpu strobe; the mask level rides along unchanged
	task automatic pulse(input logic [6:0] v);
		@(posedge clock);
		cpu <= cpu_status_t'(v | {5'h00, mask_lvl, 1'b0});
		@(posedge clock);
		cpu <= cpu_status_t'({5'h00, mask_lvl, 1'b0});
	endtask : pulse

	// 0: pin released, 1: internal reset gone, 2: core clocks back
	task automatic wait_for(input int which, input int exp);
		int n;
		n = 0;
		while (n < 40000 && (which == 0 ? pin_oe !== 1'b0 :
			which == 1 ? int_rst !== 1'b0 : core_en !== 1'b1)) begin
			@(posedge clock);
			n++;
		end
		check_near(ticks - t0, exp);
	endtask : wait_for

	// strobe with the current mask, then the mask the cpu leaves behind
	task automatic irq_step(input logic [7:0] pend, input logic [6:0] v,
		input logic m);
		@(posedge clock);
		irq_pending <= pend;
		cpu <= cpu_status_t'(v | {5'h00, mask_lvl, 1'b0});
		@(posedge clock);
		mask_lvl = m;
		cpu <= cpu_status_t'({5'h00, m, 1'b0});
		repeat (3) @(posedge clock);
	endtask : irq_step

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict

	// watchdog: whole run is about 51k clocks
	initial begin
		#900000;
		err_total++;
		$display("unexpected at %0t: run hung", $time);
		print_verdict();
	end

	initial begin
		nrst = 1'b0;
		{ext_low, low_supply, psel, penable, pwrite, mask_lvl} = 6'h00;
		paddr = '0;
		pwdata = '0;
		irq_pending = '0;
		cpu = '0;
		repeat (3) @(posedge clock);
		check_val(int_rst, 32'h1);
		check_val(core_en, 32'h0);
		check_val(gen_en, 32'h1);
		check_val(pin_oe, 32'h1);
		nrst <= 1'b1;
		t0 = ticks;
		wait_for(0, 4096);
		wait_for(1, 4160);
		apb(1'b0, `APB_OFS_CAUSE, 32'h0);
		check_val(rd, 32'h01);
		apb(1'b0, `APB_OFS_CAUSE, 32'h0);
		check_val(rd, 32'h00);
		apb(1'b0, 12'h014, 32'h0);
		check_val({rd[30:0], rerr}, 32'h1);
		// internal sources: illegal op, illegal fetch, stop while disabled
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, `APB_OFS_OPTIONS, 32'h0);
			pulse(src[i]);
			t0 = ticks;
			repeat (6) @(posedge clock);
			check_val(int_rst, 32'h1);
			check_val(pin_oe, 32'h1);
			wait_for(0, 32);
			wait_for(1, 64);
			apb(1'b0, `APB_OFS_CAUSE, 32'h0);
			check_val(rd, cause_exp[i]);
		end
		pulse(7'h08);
		repeat (10) @(posedge clock);
		check_val(int_rst, 32'h0);
		// stop recovery, short option then long
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, `APB_OFS_OPTIONS, i ? 32'h1 : 32'h3);
			pulse(7'h20);
			repeat (4) @(posedge clock);
			check_val(stop_act, 32'h1);
			check_val(gen_en, 32'h0);
			irq_pending <= 8'h04;
			t0 = ticks;
			wait_for(2, i ? 4096 : 32);
			irq_pending <= 8'h00;
		end
		low_supply <= 1'b1;
		t0 = ticks;
		repeat (4) @(posedge clock);
		low_supply <= 1'b0;
		wait_for(0, 4096);
		wait_for(1, 4160);
		apb(1'b0, `APB_OFS_CAUSE, 32'h0);
		check_val(rd, 32'h20);
		ext_low <= 1'b1;
		repeat (20) @(posedge clock);
		ext_low <= 1'b0;
		repeat (4) @(posedge clock);
		apb(1'b0, `APB_OFS_CAUSE, 32'h0);
		check_val(rd, 32'h02);
		check_val(pin_out, 32'h0);
		apb(1'b1, `APB_OFS_SERVICE, 32'h5a);
		apb(1'b0, `APB_OFS_STATUS, 32'h0);
		check_val(rd & 32'h1fff, 32'h0100);
		// interrupts: lowest index wins, latched grant holds until return
		apb(1'b1, `APB_OFS_IRQ_ENABLE, 32'hff);
		irq_step(8'h06, 7'h04, 1'b1);
		check_val(grant, 32'h9);
		irq_step(8'h07, 7'h04, 1'b1);
		check_val(grant, 32'h9);
		mask_lvl = 1'b0;
		irq_step(8'h01, 7'h01, 1'b1);
		check_val(grant, 32'h8);
		mask_lvl = 1'b0;
		irq_step(8'h00, 7'h01, 1'b0);
		check_val(grant, 32'h0);
		mask_lvl = 1'b1;
		irq_step(8'h02, 7'h04, 1'b1);
		check_val(grant, 32'h0);
		mask_lvl = 1'b0;
		apb(1'b1, `APB_OFS_IRQ_ENABLE, 32'h0);
		irq_step(8'h02, 7'h04, 1'b0);
		check_val(grant, 32'h0);
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
